// *** src/nsg_top.v ***
// Purpose: Noise shaping mode and gain control with an APB register file.
// Assumes: Serial and pin inputs synchronous to pclk; sample_tick marks one
//          sampling-clock cycle.
// Notes:   Behaviour below.
// Notes on behaviour
// - Reset leaves shaping off; register bit or control pins enable it.
// - Shaped floor center lies midway between the two corner frequencies.
// - Codes 0-7 map 0.250..0.420, codes 8-F map 0.000..0.230.
// - Shaping adds four sample cycles of latency, 26 in total.
// - Serial enable becomes active 10 sample cycles after 16th falling edge.
// - After disable, unshaped samples resume 6 sample cycles later.
// - Shaping adds no group delay, only fixed pipeline latency changes.
// - Gain selectable 0 to 6 dB in 0.5 dB steps, range scales.
// - Gain is 0 dB after reset until programmed.
// - A reference-select bit chooses internal or external reference.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "nsg_regs.vh"
module nsg_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        sample_tick,
  input  wire        sclk_fall,
  input  wire        control_pin_one,
  input  wire        control_pin_two,
  input  wire        control_pin_three,
  output reg         shaping_active,
  output reg  [3:0]  active_corner_first,
  output reg  [3:0]  active_corner_second,
  output reg  [10:0] center_milli2,
  output reg  [4:0]  pipeline_latency,
  output reg  [3:0]  gain_half_db,
  output reg         ref_external
);
  localparam ST_OFF    = 2'h0;
  localparam ST_SEROFF = 2'h1;
  localparam ST_WAITON = 2'h2;
  localparam ST_ON     = 2'h3;

  reg        reg_enable;
  reg [3:0]  corner_code_first;
  reg [3:0]  corner_code_second;
  reg [1:0]  state;
  reg [4:0]  edge_count;
  reg [3:0]  delay_count;
  reg        edges_done;
  wire [9:0] freq_first;
  wire [9:0] freq_second;
  wire       wr_en;
  wire       rd_en;
  wire       pins_on;
  wire       want_on;
  wire       mapped;

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign mapped  = (paddr == `NSG_OFF_CTRL) | (paddr == `NSG_OFF_COEF) |
                   (paddr == `NSG_OFF_GAIN) | (paddr == `NSG_OFF_STATUS) |
                   (paddr == `NSG_OFF_LATENCY);
  assign pslverr = psel & penable & ~mapped;
  // Any high pin enables; the bit must stay clear when pins rule.
  assign pins_on = control_pin_one | control_pin_two |
                   control_pin_three;
  assign want_on = reg_enable | pins_on;

  // Writes take effect at the access edge; gain above 6 dB is clamped.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_enable         <= 1'b0;
      ref_external       <= 1'b0;
      corner_code_first  <= 4'h0;
      corner_code_second <= 4'h0;
      gain_half_db       <= `NSG_GAIN_RESET;
    end else if (wr_en) begin
      case (paddr)
        `NSG_OFF_CTRL: begin
          reg_enable   <= pwdata[`NSG_CTRL_EN_BIT];
          ref_external <= pwdata[`NSG_CTRL_REF_BIT];
        end
        `NSG_OFF_COEF: begin
          corner_code_first  <= pwdata[3:0];
          corner_code_second <= pwdata[7:4];
        end
        `NSG_OFF_GAIN: begin
          if (pwdata[3:0] > `NSG_GAIN_MAX) begin
            gain_half_db <= `NSG_GAIN_MAX;
          end else begin
            gain_half_db <= pwdata[3:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (paddr)
      `NSG_OFF_CTRL:    prdata = {30'h0, ref_external, reg_enable};
      `NSG_OFF_COEF:    prdata = {24'h0, corner_code_second,
                                  corner_code_first};
      `NSG_OFF_GAIN:    prdata = {28'h0, gain_half_db};
      `NSG_OFF_STATUS:  prdata = {21'h0, center_milli2};
      `NSG_OFF_LATENCY: prdata = {24'h0, state, shaping_active,
                                  pipeline_latency};
      default:          prdata = 32'h00000000;
    endcase
    if (!rd_en) begin
      prdata = 32'h00000000;
    end
  end

  nsg_corner_lut u_lut_first (
    .code       (active_corner_first),
    .freq_milli (freq_first)
  );
  nsg_corner_lut u_lut_second (
    .code       (active_corner_second),
    .freq_milli (freq_second)
  );

  // A register enable waits for the 16th serial falling edge of the frame
  // that carried it; the edge count restarts only when the block leaves the off state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                <= ST_OFF;
      edge_count           <= 5'h00;
      delay_count          <= 4'h0;
      edges_done           <= 1'b0;
      shaping_active       <= 1'b0;
      active_corner_first  <= 4'h0;
      active_corner_second <= 4'h0;
      pipeline_latency     <= `NSG_LAT_BASE;
      center_milli2        <= 11'h000;
    end else begin
      center_milli2 <= {1'b0, freq_first} + {1'b0, freq_second};
      case (state)
        ST_OFF: begin
          if (want_on) begin
            state       <= ST_WAITON;
            delay_count <= 4'h0;
            edge_count  <= 5'h00;
            edges_done  <= ~reg_enable;
          end
        end
        ST_WAITON: begin
          if (!want_on) begin
            state <= ST_OFF;
          end else if (!edges_done) begin
            if (sclk_fall) begin
              edge_count <= edge_count + 5'h01;
              if (edge_count == `NSG_SCLK_EDGES - 1) begin
                edges_done <= 1'b1;
              end
            end
          end else if (sample_tick) begin
            if (delay_count == `NSG_ON_DELAY - 1) begin
              state                <= ST_ON;
              shaping_active       <= 1'b1;
              active_corner_first  <= corner_code_first;
              active_corner_second <= corner_code_second;
              // Latency grows only; no group delay is added.
              pipeline_latency <= `NSG_LAT_BASE + `NSG_LAT_EXTRA;
            end else begin
              delay_count <= delay_count + 4'h1;
            end
          end
        end
        ST_ON: begin
          active_corner_first  <= corner_code_first;
          active_corner_second <= corner_code_second;
          if (!want_on) begin
            state       <= ST_SEROFF;
            delay_count <= 4'h0;
          end
        end
        ST_SEROFF: begin
          if (sample_tick) begin
            if (delay_count == `NSG_OFF_DELAY - 1) begin
              state            <= ST_OFF;
              shaping_active   <= 1'b0;
              pipeline_latency <= `NSG_LAT_BASE;
            end else begin
              delay_count <= delay_count + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end
endmodule

// *** shared/nsg_regs.vh ***
// Purpose: Offsets, fields, reset values and timing counts of the shaping
//          and gain control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef NSG_REGS_VH
`define NSG_REGS_VH

`define NSG_OFF_CTRL       12'h000
`define NSG_OFF_COEF       12'h004
`define NSG_OFF_GAIN       12'h008
`define NSG_OFF_STATUS     12'h00C
`define NSG_OFF_LATENCY    12'h010

`define NSG_CTRL_EN_BIT    0
`define NSG_CTRL_REF_BIT   1
`define NSG_CTRL_RESET     32'h00000000
`define NSG_COEF_RESET     32'h00000000
`define NSG_GAIN_RESET     4'h0
`define NSG_GAIN_MAX       4'hC

`define NSG_LAT_BASE       5'h16
`define NSG_LAT_EXTRA      5'h04
`define NSG_ON_DELAY       10
`define NSG_OFF_DELAY      6
`define NSG_SCLK_EDGES     16

`endif

// *** src/nsg_corner_lut.v ***
// Purpose: Maps a four-bit corner code to a normalized corner frequency.
// Assumes: Output is the frequency over the sample rate times 1000.
// Notes:   Pure lookup, instantiated once per corner code.
`timescale 1ns/1ps
module nsg_corner_lut (
  input  wire [3:0] code,
  output reg  [9:0] freq_milli
);
  // Codes 0..7 rise from 0.250 to 0.420, codes 8..F rise from 0.000.
  always @* begin
    case (code)
      4'h0: freq_milli = 10'h0FA;
      4'h1: freq_milli = 10'h10E;
      4'h2: freq_milli = 10'h122;
      4'h3: freq_milli = 10'h137;
      4'h4: freq_milli = 10'h14D;
      4'h5: freq_milli = 10'h165;
      4'h6: freq_milli = 10'h181;
      4'h7: freq_milli = 10'h1A4;
      4'h8: freq_milli = 10'h000;
      4'h9: freq_milli = 10'h050;
      4'hA: freq_milli = 10'h073;
      4'hB: freq_milli = 10'h08F;
      4'hC: freq_milli = 10'h0A7;
      4'hD: freq_milli = 10'h0BD;
      4'hE: freq_milli = 10'h0D2;
      4'hF: freq_milli = 10'h0E6;
      default: freq_milli = 10'h000;
    endcase
  end
endmodule

// *** test/nsg_host_model.sv ***
// Purpose: Host side: sampling ticks and serial clock fall bursts.
// Assumes: One pclk domain; every pulse is one cycle wide.
// Notes:   Falls sit off the tick phase so their order is never ambiguous.
`timescale 1ns/1ps
module nsg_host_model (
  input  wire pclk,
  input  wire presetn,
  input  wire burst,
  output wire sample_tick,
  output wire sclk_fall,
  output wire burst_done
);
  reg [1:0] phase;
  reg [4:0] falls;
  assign sample_tick = (phase == 2'h0);
  assign sclk_fall   = (falls != 5'h00) && (phase == 2'h2);
  assign burst_done  = (falls == 5'h00);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      falls <= 5'h00;
    end else begin
      phase <= phase + 2'h1;
      if (burst)
        falls <= 5'h10;
      else if (sclk_fall)
        falls <= falls - 5'h01;
    end
  end
endmodule

// *** test/nsg_top_checker.sv ***
// Purpose: Port level assertions for the shaping and gain block.
// Assumes: Single pclk domain, asynchronous active low reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module nsg_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sample_tick,
  input wire        shaping_active,
  input wire [4:0]  pipeline_latency,
  input wire [3:0]  gain_half_db,
  input wire        ref_external
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       wr    = psel && penable && pwrite;
  wire [3:0] wgain = pwdata[3:0];
  wire       wref  = pwdata[1];
  a_latency_mode: assert property
    (pipeline_latency == (shaping_active ? 5'h1A : 5'h16))
    else $error("latency does not match mode");
  a_gain_limit: assert property (gain_half_db <= 4'hC)
    else $error("gain above 6 dB");
  a_gain_write: assert property (wr && paddr == 12'h008 |=>
    gain_half_db == (($past(wgain) > 4'hC) ? 4'hC : $past(wgain)))
    else $error("gain write not applied");
  a_ref_write: assert property (wr && paddr == 12'h000 |=>
    ref_external == $past(wref)) else $error("reference bit lost");
  a_on_at_tick: assert property
    ($rose(shaping_active) |-> $past(sample_tick))
    else $error("shaping rose off a tick");
  a_off_at_tick: assert property
    ($fell(shaping_active) |-> $past(sample_tick))
    else $error("shaping fell off a tick");
  a_reset_state: assert property ($rose(presetn) |->
    !shaping_active && gain_half_db == 4'h0 && pipeline_latency == 5'h16)
    else $error("bad state after reset");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h010
    |-> pslverr) else $error("unmapped access not refused");
endmodule
bind nsg_top nsg_checker i_nsg_checker (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .sample_tick,
  .shaping_active, .pipeline_latency, .gain_half_db, .ref_external);

// *** test/nsg_top_tb.sv ***
// Purpose: Self-checking bench for the shaping and gain block.
// Assumes: Zero wait APB slave; a sample tick every fourth pclk.
// Notes:   Reads are compared by a monitor against a queue of notes.
`timescale 1ns/1ps
`include "nsg_regs.vh"
module nsg_top_tb;
  localparam [159:0] FQ = {10'd230, 10'd210, 10'd189, 10'd167, 10'd143,
    10'd115, 10'd80, 10'd0, 10'd420, 10'd385, 10'd357, 10'd333, 10'd311,
    10'd290, 10'd270, 10'd250};
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [2:0]  pins = 3'h0;
  reg         burst = 1'b0;
  reg  [3:0]  a;
  reg  [3:0]  b;
  wire [31:0] prdata;
  wire        pready;
  wire        sample_tick;
  wire        sclk_fall;
  wire        burst_done;
  wire        shaping_active;
  wire        slv_err;
  wire [3:0]  corner_first;
  wire [3:0]  corner_second;
  reg  [31:0] exp_q[$];
  reg  [31:0] msk_q[$];
  integer     n_fail = 0;
  integer     samples_checked = 0;
  integer     seed = 32'hce80;
  integer     i, k, g;
  always #12.5 pclk = ~pclk;
  nsg_host_model i_nsg_host_model (.pclk(pclk), .presetn(presetn),
    .burst(burst), .sample_tick(sample_tick), .sclk_fall(sclk_fall),
    .burst_done(burst_done));
  nsg_top i_nsg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(slv_err),
    .sample_tick(sample_tick),
    .sclk_fall(sclk_fall), .control_pin_one(pins[0]),
    .control_pin_two(pins[1]), .control_pin_three(pins[2]),
    .shaping_active(shaping_active), .active_corner_first(corner_first),
    .active_corner_second(corner_second), .center_milli2(),
    .pipeline_latency(),
    .gain_half_db(), .ref_external());
  task print_verdict;
    begin
      if (n_fail == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task check(input [11:0] ad, input [31:0] seen, input [31:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        n_fail = n_fail + 1;
        $display("mismatch addr %h exp %h seen %h", ad, want, seen);
      end
    end
  endtask
  task apb(input w, input [11:0] ad, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (k = 0; k < 50 && pready !== 1'b1; k = k + 1) @(posedge pclk);
      if (k == 50) begin
        n_fail = n_fail + 1;
        print_verdict;
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] ad, input [31:0] want, input [31:0] msk);
    begin
      exp_q.push_back(want);
      msk_q.push_back(msk);
      apb(1'b0, ad, 32'h00000000);
    end
  endtask
  // Counts ticks until the mode settles; a bounded wait, never open-ended.
  task ticks(input want, input integer n);
    begin
      k = 0;
      for (i = 0; i < 400 && shaping_active !== want; i = i + 1) begin
        @(posedge pclk);
        if (sample_tick === 1'b1 && shaping_active !== want) k = k + 1;
      end
      if (i == 400) begin
        n_fail = n_fail + 1;
        print_verdict;
      end
      check(12'hFFF, k, n);
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check(paddr, prdata & msk_q.pop_front(), exp_q.pop_front());
    // Only the probe address lies outside the map; it must be refused.
    if (psel && penable && pready === 1'b1)
      check(paddr, {31'h0, slv_err}, {31'h0, paddr == 12'h020});
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`NSG_OFF_CTRL, 32'h0, 32'h3);
    rd(`NSG_OFF_LATENCY, 32'h16, 32'h3F);
    for (g = 0; g < 16; g = g + 1) begin
      apb(1'b1, `NSG_OFF_GAIN, g);
      rd(`NSG_OFF_GAIN, (g > 12) ? 12 : g, 32'hF);
    end
    for (g = 0; g < 4; g = g + 1) begin
      a = $random(seed);
      b = (g == 0) ? 4'h8 : $random(seed);
      apb(1'b1, `NSG_OFF_COEF, {24'h0, b, a});
      apb(1'b1, `NSG_OFF_CTRL, 32'h1);
      burst <= 1'b1;
      @(posedge pclk);
      burst <= 1'b0;
      @(posedge pclk);
      for (i = 0; i < 99 && burst_done !== 1'b1; i = i + 1) @(posedge pclk);
      if (i == 99) begin
        n_fail = n_fail + 1;
        print_verdict;
      end
      ticks(1'b1, 10);
      check(12'hFFE, {corner_second, corner_first}, {b, a});
      rd(`NSG_OFF_STATUS, FQ[a*10 +: 10] + FQ[b*10 +: 10], 32'h7FF);
      rd(`NSG_OFF_LATENCY, 32'h3A, 32'h3F);
      apb(1'b1, `NSG_OFF_CTRL, 32'h0);
      // The block leaves the on state one edge after the write lands.
      @(posedge pclk);
      ticks(1'b0, 6);
    end
    apb(1'b1, `NSG_OFF_CTRL, 32'h2);
    rd(`NSG_OFF_CTRL, 32'h2, 32'h3);
    apb(1'b1, `NSG_OFF_CTRL, 32'h0);
    for (g = 0; g < 3; g = g + 1) begin
      for (i = 0; i < 8 && sample_tick !== 1'b1; i = i + 1) @(posedge pclk);
      pins <= 3'h1 << g;
      ticks(1'b1, 10);
      pins <= 3'h0;
      ticks(1'b0, 6);
    end
    rd(12'h020, 32'h0, 32'hFFFFFFFF);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(`NSG_OFF_GAIN, 32'h0, 32'hF);
    print_verdict;
  end
endmodule
